// >>> splc_consts.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * serial port lock and configuration register bank.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef SPLC_CONSTS_SVH
`define SPLC_CONSTS_SVH

// Register addresses on the internal register access port
`define SPLC_ADDR_W            16
`define SPLC_OFS_LPLEVEL       16'hEC00
`define SPLC_OFS_REFLOCK       16'hEC01

// Low-power overcurrent level fields
`define SPLC_THR_LSB           0
`define SPLC_THR_W             3
`define SPLC_THR_RST           3'h7
`define SPLC_LINE_LSB          3
`define SPLC_LINE_W            5
`define SPLC_LINE_RST          5'h00
`define SPLC_THR_DIV           8

// Reference and port lock fields
`define SPLC_EXTREF_BIT        0
`define SPLC_LOCK_BIT          1
`define SPLC_REFLOCK_RST       8'h00

// Measurement period: (line count + 1) / 50 s, in system clocks
`define SPLC_LINE_RATE_HZ      50
`define SPLC_CLK_HZ            10000000
`define SPLC_LINE_CYCLES       (`SPLC_CLK_HZ / `SPLC_LINE_RATE_HZ)

// Strobe toggles needed to switch to the four-wire port
`define SPLC_TOGGLES_TO_SWITCH 3

`endif

// >>> splc_pkg.sv
/*
 * Types for the serial port lock and configuration register bank.
 * Assumes splc_consts.svh is on the include path.
 */
`include "splc_consts.svh"

package splc_pkg;

    // Register access request from the serial protocol engines
    typedef struct packed {
        logic                      wr;    // Write strobe, one cycle
        logic [`SPLC_ADDR_W-1:0]   addr;  // Register address
        logic [7:0]                wdata; // Write data
    } splc_req_t;

    // Port selection state, one-hot
    typedef enum logic [2:0] {
        SPLC_TWO_OPEN  = 3'h1, // Two-wire active, not locked
        SPLC_TWO_LOCK  = 3'h2, // Two-wire locked in
        SPLC_FOUR_PORT = 3'h4  // Four-wire active (locked on write)
    } splc_port_t;

endpackage

// >>> splc_toggle_count.sv
/*
 * Counts toggles of the select/strobe pin after a three-flop synchroniser.
 * Assumes the pin is asynchronous to the system clock.
 */
`timescale 1ns/1ns
`include "splc_consts.svh"

module splc_toggle_count (
    input  wire logic i_clk_sys,   // System clock
    input  wire logic i_sys_rst,   // Async reset, active high
    input  wire logic i_clk_en,    // Clock enable
    input  wire logic i_pin,       // Raw select/strobe pin
    input  wire logic i_arm,       // Counting allowed
    output logic      o_reached    // Toggle target reached, one cycle
);
    // State of this module
    typedef struct packed {
        logic [2:0] sync;  // Synchroniser stages
        logic [1:0] cnt;   // Toggles seen
        logic       done;  // Target pulse
        logic       level; // Last settled pin level
    } splc_tc_t;

    splc_tc_t st;
    splc_tc_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Next state: a toggle counts once stages two and three agree on a new level
    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[1:0], i_pin};
        next_st.done = 1'b0;
        if (st.sync[2] == st.sync[1]) begin
            // Settled level is tracked even while disarmed
            next_st.level = st.sync[2];
        end
        if (!i_arm) begin
            // Locked or already switched: ignore the pin
            next_st.cnt = 2'h0;
        end else if (st.sync[2] == st.sync[1] && st.sync[2] != st.level) begin
            if (st.cnt == 2'(`SPLC_TOGGLES_TO_SWITCH - 1)) begin
                next_st.cnt  = 2'h0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 2'h1;
            end
        end
    end

    // Register stage
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    assign o_reached = st.done;
endmodule

// >>> splc_top.sv
/*
 * Low-power overcurrent level and reference / port lock registers with
 * the serial port selection lock.
 * Assumes the protocol engines present one-cycle write strobes and a
 * combinational read address on the system clock.
 */
`timescale 1ns/1ns
`include "splc_consts.svh"

// How it works
// - Threshold equals full scale times code over eight
// - Period is line count plus one over fifty
// - Reference bit selects internal or external reference
// - Unlocked: three strobe toggles select four-wire port
// - Lock bit set in two-wire: strobe ignored, stays two-wire
// - Four-wire write to second register locks port
// - Lock survives every power mode change
module splc_top #(
    parameter int unsigned LINE_CYCLES = `SPLC_LINE_CYCLES  // Clocks per 1/50 s
) (
    input  wire logic                       i_clk_sys,       // System clock
    input  wire logic                       i_sys_rst,       // Async reset
    input  wire logic                       i_clk_en,        // Clock enable
    input  wire splc_pkg::splc_req_t        i_req,           // Register access
    output logic [7:0]                      o_rdata,         // Read data
    input  wire logic                       i_select_strobe_pin, // Raw pin
    input  wire logic [1:0]                 i_power_mode_states, // Power mode
    output logic [`SPLC_THR_W-1:0]          o_lowpower_threshold_code,
    output logic [`SPLC_LINE_W-1:0]         o_lowpower_line_count,
    output logic                            o_period_tick,   // Period end pulse
    output logic                            o_external_reference_select,
    output logic                            o_four_wire_active, // Port select
    output logic                            o_port_locked    // Lock state
);
    // Elaboration check: the period pulse needs at least two clocks per step
    if (LINE_CYCLES < 2) begin : g_line_check
        $error("LINE_CYCLES too small");
    end

    // Write decode helper
    function automatic logic hit(input splc_pkg::splc_req_t r,
                                 input logic [`SPLC_ADDR_W-1:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // All state of the block
    typedef struct packed {
        logic [7:0]         lplevel;  // Low-power overcurrent level
        logic [7:0]         reflock;  // Reference and lock register
        splc_pkg::splc_port_t port;   // Port selection state
        logic [31:0]        tick_cnt; // Clocks within one 1/50 s
        logic [4:0]         line_cnt; // Sub-periods elapsed
        logic               tick;     // Period pulse
        logic [7:0]         rdata;    // Read data flop
    } splc_st_t;

    splc_st_t st;
    splc_st_t next_st;
    logic     toggles_done; // Three toggles seen
    logic     arm;          // Pin may count

    ////////////////////////////////////////////////////////////////////////
    // Strobe toggle counter, armed only while two-wire and unlocked
    assign arm = (st.port == splc_pkg::SPLC_TWO_OPEN);

    splc_toggle_count u_tc (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_pin     (i_select_strobe_pin),
        .i_arm     (arm),
        .o_reached (toggles_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        // Register writes
        if (hit(i_req, `SPLC_OFS_LPLEVEL)) begin
            next_st.lplevel = i_req.wdata;
        end
        if (hit(i_req, `SPLC_OFS_REFLOCK)) begin
            // Lock bit is sticky: a zero never clears it
            next_st.reflock[`SPLC_EXTREF_BIT] = i_req.wdata[`SPLC_EXTREF_BIT];
            next_st.reflock[`SPLC_LOCK_BIT] = st.reflock[`SPLC_LOCK_BIT]
                                              | i_req.wdata[`SPLC_LOCK_BIT];
        end
        // Port selection; power mode plays no part, so it is retained
        case (st.port)
            splc_pkg::SPLC_TWO_OPEN: begin
                if (hit(i_req, `SPLC_OFS_REFLOCK) && i_req.wdata[`SPLC_LOCK_BIT]) begin
                    next_st.port = splc_pkg::SPLC_TWO_LOCK;
                end else if (toggles_done) begin
                    next_st.port = splc_pkg::SPLC_FOUR_PORT;
                end
            end
            splc_pkg::SPLC_TWO_LOCK: begin
                // Strobe toggles can no longer reach the four-wire port
                next_st.port = splc_pkg::SPLC_TWO_LOCK;
            end
            splc_pkg::SPLC_FOUR_PORT: begin
                // No path back to the two-wire port
                next_st.port = splc_pkg::SPLC_FOUR_PORT;
            end
            default: begin
                // Illegal code: fall back to the reset choice
                next_st.port = splc_pkg::SPLC_TWO_OPEN;
            end
        endcase
        // Four-wire: any write to the second register locks
        if (st.port == splc_pkg::SPLC_FOUR_PORT && hit(i_req, `SPLC_OFS_REFLOCK)) begin
            next_st.reflock[`SPLC_LOCK_BIT] = 1'b1;
        end
        // Measurement period timer
        if (st.tick_cnt == LINE_CYCLES - 1) begin
            next_st.tick_cnt = 32'h0;
            if (st.line_cnt >= st.lplevel[`SPLC_LINE_LSB +: `SPLC_LINE_W]) begin
                next_st.line_cnt = 5'h00;
                next_st.tick     = 1'b1;
            end else begin
                next_st.line_cnt = st.line_cnt + 5'h01;
            end
        end else begin
            next_st.tick_cnt = st.tick_cnt + 32'h1;
        end
        // Read mux, reserved bits read zero
        case (i_req.addr)
            `SPLC_OFS_LPLEVEL: next_st.rdata = st.lplevel;
            `SPLC_OFS_REFLOCK: next_st.rdata = {6'h00, st.reflock[1:0]};
            default:           next_st.rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register stage; only device reset restores defaults
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st.lplevel  <= {`SPLC_LINE_RST, `SPLC_THR_RST};
            st.reflock  <= `SPLC_REFLOCK_RST;
            st.port     <= splc_pkg::SPLC_TWO_OPEN;
            st.tick_cnt <= 32'h0;
            st.line_cnt <= 5'h00;
            st.tick     <= 1'b0;
            st.rdata    <= 8'h00;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    // Outputs
    assign o_rdata                     = st.rdata;
    assign o_lowpower_threshold_code   = st.lplevel[`SPLC_THR_LSB +: `SPLC_THR_W];
    assign o_lowpower_line_count       = st.lplevel[`SPLC_LINE_LSB +: `SPLC_LINE_W];
    assign o_period_tick               = st.tick;
    assign o_external_reference_select = st.reflock[`SPLC_EXTREF_BIT];
    assign o_four_wire_active          = (st.port == splc_pkg::SPLC_FOUR_PORT);
    assign o_port_locked               = st.reflock[`SPLC_LOCK_BIT]
                                         | (st.port == splc_pkg::SPLC_TWO_LOCK);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // Each write is checked on the following edge; reads are checked against
    // the register outputs as they stood when the address was taken.

    thr_write_a: assert property (
        i_clk_en && hit(i_req, `SPLC_OFS_LPLEVEL)
        |=> o_lowpower_threshold_code == $past(i_req.wdata[2:0]))
        else $error("threshold code not stored");
    line_write_a: assert property (
        i_clk_en && hit(i_req, `SPLC_OFS_LPLEVEL)
        |=> o_lowpower_line_count == $past(i_req.wdata[7:3]))
        else $error("line count not stored");
    ref_write_a: assert property (
        i_clk_en && hit(i_req, `SPLC_OFS_REFLOCK)
        |=> o_external_reference_select == $past(i_req.wdata[0]))
        else $error("reference select not stored");
    four_switch_a: assert property (
        i_clk_en && arm && toggles_done && !hit(i_req, `SPLC_OFS_REFLOCK)
        |=> o_four_wire_active)
        else $error("no switch after three toggles");
    two_lock_a: assert property (
        st.port == splc_pkg::SPLC_TWO_LOCK
        |=> !o_four_wire_active)
        else $error("locked two-wire port switched");
    two_set_a: assert property (
        i_clk_en && st.port == splc_pkg::SPLC_TWO_OPEN && hit(i_req, `SPLC_OFS_REFLOCK)
        && i_req.wdata[`SPLC_LOCK_BIT] |=> o_port_locked && !o_four_wire_active)
        else $error("two-wire lock write not taken");
    four_lock_a: assert property (
        i_clk_en && o_four_wire_active && hit(i_req, `SPLC_OFS_REFLOCK)
        |=> o_port_locked)
        else $error("four-wire write did not lock");
    four_keep_a: assert property (
        o_four_wire_active
        |=> o_four_wire_active)
        else $error("four-wire selection lost");
    mode_keep_a: assert property (
        $changed(i_power_mode_states) && o_port_locked
        |=> o_port_locked && o_four_wire_active == $past(o_four_wire_active))
        else $error("port choice lost on power mode change");
    lock_keep_a: assert property (
        o_port_locked
        |=> o_port_locked)
        else $error("lock cleared without reset");
    rd_level_a: assert property (
        i_clk_en && i_req.addr == `SPLC_OFS_LPLEVEL
        |=> o_rdata == {$past(o_lowpower_line_count), $past(o_lowpower_threshold_code)})
        else $error("level register read wrong");
    rd_ref_a: assert property (
        i_clk_en && i_req.addr == `SPLC_OFS_REFLOCK
        |=> o_rdata == {6'h00, $past(o_port_locked), $past(o_external_reference_select)})
        else $error("reference register read wrong");

    // Main scenarios
    four_seen_c: cover property (o_four_wire_active);
    two_lock_c: cover property (st.port == splc_pkg::SPLC_TWO_LOCK);
    four_lock_c: cover property (o_four_wire_active && o_port_locked);
    tick_c: cover property (o_period_tick);
    mode_lock_c: cover property (o_port_locked && $changed(i_power_mode_states));
endmodule

// >>> splc_host_model.sv
/*
 * Behavioural host controller on the serial port: register writes and
 * reads, and toggles of the select/strobe pin, all driven at rising edges.
 * Assumes the bank samples requests on the rising system clock edge.
 */
`timescale 1ns/1ns
`include "splc_consts.svh"

module splc_host_model (
    input  wire logic           i_clk_sys, // System clock
    input  wire logic [7:0]     i_rdata,   // Read data from the bank
    output splc_pkg::splc_req_t o_req,     // Register request
    output logic                o_pin      // Select/strobe pin
);
    // Idle bus and low pin from time zero
    initial begin
        o_req = '0;
        o_pin = 1'b0;
    end

    // One-cycle write strobe, address and data held over the taking edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clk_sys);
        o_req.wr <= 1'b0;
        #1;
    endtask

    // Address presented, data taken one system clock later
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_req.addr <= a;
        @(posedge i_clk_sys);
        #1;
        d = i_rdata;
    endtask

    // One pin level change, then enough settling for the synchroniser
    task automatic toggle();
        @(posedge i_clk_sys);
        o_pin <= ~o_pin;
        repeat (4) @(posedge i_clk_sys);
        #1;
    endtask

    // Two-wire host pins its port choice
    task automatic lock_two_wire();
        wr(`SPLC_OFS_REFLOCK, 8'h02);
    endtask
endmodule

// >>> tb.sv
/*
 * Self-checking bench for the port lock and configuration bank.
 * Assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ns
`include "splc_consts.svh"

module tb;
    logic                clk    = 1'b0; // 10 MHz system clock
    logic                rst    = 1'b1; // Async reset
    logic                clk_en = 1'b1; // Clock enable
    logic [1:0]          pmode  = 2'h0; // Power mode
    splc_pkg::splc_req_t req;           // Host request
    logic                pin;           // Select/strobe pin
    logic [7:0]          rdata;         // Read data
    logic [2:0]          thr;           // Threshold code
    logic [4:0]          line;          // Line count
    logic                tick;          // Period pulse
    logic                extref;        // External reference
    logic                four;          // Four-wire active
    logic                locked;        // Port locked
    int                  err_count   = 0;
    int                  check_count = 0;

    // Clock
    always #50 clk = ~clk;

    splc_top #(.LINE_CYCLES(4)) u_dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_req(req),
        .o_rdata(rdata), .i_select_strobe_pin(pin), .i_power_mode_states(pmode),
        .o_lowpower_threshold_code(thr), .o_lowpower_line_count(line),
        .o_period_tick(tick), .o_external_reference_select(extref),
        .o_four_wire_active(four), .o_port_locked(locked));

    splc_host_model u_host (.i_clk_sys(clk), .i_rdata(rdata), .o_req(req), .o_pin(pin));

    // Byte comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register read and comparison
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask

    // Cycles from one period pulse to the next
    task automatic period(input logic [7:0] exp);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 300);
        chk(n[7:0], exp);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    // Test sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({5'h00, thr}, 8'h07);
        chk({6'h00, locked, extref}, 8'h00);
        chk_rd(`SPLC_OFS_LPLEVEL, 8'h07);
        period(8'd4);
        // Every threshold code with a matching line count
        for (int i = 0; i < 8; i++) begin
            u_host.wr(`SPLC_OFS_LPLEVEL, {5'(i), 3'(7 - i)});
            chk({5'h00, thr}, 8'(7 - i));
            chk({3'h0, line}, 8'(i));
            chk_rd(`SPLC_OFS_LPLEVEL, {5'(i), 3'(7 - i)});
        end
        repeat (40) @(posedge clk);
        period(8'd32);
        // Unmapped place and frozen clock enable leave the bank alone
        u_host.wr(16'hEC02, 8'hFF);
        chk_rd(16'hEC02, 8'h00);
        @(posedge clk);
        clk_en <= 1'b0;
        u_host.wr(`SPLC_OFS_LPLEVEL, 8'hFF);
        @(posedge clk);
        clk_en <= 1'b1;
        chk_rd(`SPLC_OFS_LPLEVEL, 8'h38);
        // Reference select, reserved bits dropped
        u_host.wr(`SPLC_OFS_REFLOCK, 8'hFD);
        chk({6'h00, locked, extref}, 8'h01);
        chk_rd(`SPLC_OFS_REFLOCK, 8'h01);
        u_host.wr(`SPLC_OFS_REFLOCK, 8'h00);
        chk({7'h00, extref}, 8'h00);
        // Two toggles are not enough, the third switches
        repeat (2) u_host.toggle();
        chk({7'h00, four}, 8'h00);
        u_host.toggle();
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, four}, 8'h01);
        // Any write to the second register in four-wire locks, through every power mode
        u_host.wr(`SPLC_OFS_REFLOCK, 8'h01);
        chk({6'h00, locked, extref}, 8'h03);
        chk_rd(`SPLC_OFS_REFLOCK, 8'h03);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            pmode <= 2'(3 - m);
            repeat (2) @(posedge clk);
            #1;
            chk({6'h00, four, locked}, 8'h03);
        end
        u_host.wr(`SPLC_OFS_REFLOCK, 8'h00);
        chk_rd(`SPLC_OFS_REFLOCK, 8'h02);
        u_host.toggle();
        chk({6'h00, four, locked}, 8'h03);
        // Only reset restores the defaults
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({four, locked, extref, 2'h0, thr}, 8'h07);
        chk_rd(`SPLC_OFS_LPLEVEL, 8'h07);
        // Two-wire lock makes later toggles harmless
        u_host.lock_two_wire();
        chk({6'h00, four, locked}, 8'h01);
        repeat (3) u_host.toggle();
        repeat (3) @(posedge clk);
        #1;
        chk({6'h00, four, locked}, 8'h01);
        chk_rd(`SPLC_OFS_REFLOCK, 8'h02);
        wrap_up();
    end
endmodule
